//--- verilog/cable_diag_pkg.sv
// package for the cable diagnostic result block
// assumes a 100 MHz register clock and AXI4-Lite byte addressing
package cable_diag_pkg;
    // register indices; byte address is four times the index
    localparam logic [5:0]  IDX_CONTROL    = 6'h16;
    localparam logic [5:0]  IDX_WINDOW     = 6'h17;
    localparam logic [5:0]  IDX_PEAK       = 6'h18;
    localparam logic [5:0]  IDX_THRESHOLD  = 6'h19;
    localparam logic [5:0]  IDX_VAR_CTRL   = 6'h1A;
    localparam logic [5:0]  IDX_VAR_DATA   = 6'h1B;
    localparam int          ADDR_W         = 8;
    // control register fields
    localparam int          FIRE_BIT       = 11;
    localparam int          POLARITY_BIT   = 7;
    localparam int          LEVEL_MSB      = 5;
    localparam logic [5:0]  LEVEL_RESET    = 6'h20;
    // window, peak and threshold fields
    localparam int          BEGIN_LSB      = 8;
    localparam logic [7:0]  WINDOW_RESET   = 8'h00;
    localparam int          PEAK_LSB       = 8;
    localparam int          HIT_BIT        = 8;
    localparam logic [7:0]  TIME_LAST      = 8'hFF;
    // variance control fields
    localparam int          READY_BIT      = 15;
    localparam int          HOLD_BIT       = 3;
    localparam int          PERIOD_LSB     = 1;
    localparam int          ENABLE_BIT     = 0;
    localparam logic [1:0]  PERIOD_RESET   = 2'h0;
    // one period unit is 2^17 cycles of an 8 ns clock
    localparam int          UNIT_EXP       = 17;
    localparam int          UNIT_CLK_NS    = 8;
    localparam int          UNIT_NS        = (1 << UNIT_EXP) * UNIT_CLK_NS;
    localparam int          CLK_NS         = 10;
    localparam int          UNIT_CYCLES    = UNIT_NS / CLK_NS;
    // bus answers
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage

//--- verilog/cable_diag_results.sv
// reflectometry result capture and variance accumulator with AXI4-Lite registers
// assumes samples and variance terms arrive from logic on aclk
//
// What this block does
// - watch samples only between 8-bit begin and end times, in 8 ns units
// - results are valid once the fire bit has dropped back to zero
// - peak field holds largest sample, or smallest with negative polarity
// - peak time is the first window time the peak appeared
// - threshold-hit bit set when any windowed sample met the level
// - threshold time is window time of first sample meeting level
// - reserved bits ignore writes and read zero
// - ready flag rises on new sum, drops after two data reads
// - hold stops data updates and drops after two data reads
// - period select gives 2, 4, 6 or 8 units
// - new period value restarts computation; data loads only at period end
// - one period unit is 2^17 cycles of an 8 ns clock
// - computation runs only while enable is set; enable resets off
// - after hold, first data read gives low half, second high half
// - fire bit sends a pulse, arms capture, clears when capture ends
// - polarity zero detects positive peaks, one negative peaks
// - level met above it when positive, below it when negative
`timescale 1ns/1ps
`default_nettype none
module cable_diag_results #(
    parameter int UNIT_CYCLES = cable_diag_pkg::UNIT_CYCLES
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [5:0]  sample,
    input  wire logic        sample_valid,
    output logic             pulse_fire,
    input  wire logic [15:0] variance_term,
    input  wire logic        variance_term_valid
);
    typedef enum logic {CAP_IDLE, CAP_RUN} cap_state_e;

    cap_state_e  cap_state;
    logic        reflect_pulse_fire;
    logic        peak_polarity_select;
    logic [5:0]  trigger_level;
    logic [7:0]  reflect_window_begin;
    logic [7:0]  reflect_window_end;
    logic [5:0]  peak_value;
    logic [7:0]  reflect_peak_time;
    logic        reflect_threshold_hit;
    logic [7:0]  reflect_threshold_time;
    logic        peak_seen;
    logic [7:0]  win_time;
    logic        var_ready;
    logic        var_hold;
    logic [1:0]  var_period;
    logic        var_enable;
    logic [31:0] var_acc;
    logic [31:0] var_data;
    logic        read_high;
    logic [16:0] unit_count;
    logic [3:0]  units_done;
    logic [3:0]  units_target;
    logic        unit_tick;
    logic        period_end;
    logic        wr_go;
    logic        rd_go;
    logic [5:0]  wr_idx;
    logic [5:0]  rd_idx;
    logic [15:0] wval;
    logic        wr_fire;
    logic        wr_period_new;
    logic        rd_data_reg;
    logic        in_window;
    logic        level_met;
    logic        peak_better;
    logic        cap_last;
    logic [15:0] next_rdata;
    logic        next_rhit;

    // bus slave: write address and data taken together
    assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_wready  = s_axi_awready;
    assign s_axi_arready = s_axi_arvalid && !s_axi_rvalid;
    assign wr_go         = s_axi_awready;
    assign rd_go         = s_axi_arready;
    assign wr_idx        = s_axi_awaddr[7:2];
    assign rd_idx        = s_axi_araddr[7:2];
    assign wval          = s_axi_wdata[15:0];

    assign wr_fire = wr_go && wr_idx == cable_diag_pkg::IDX_CONTROL && s_axi_wstrb[1]
                     && wval[cable_diag_pkg::FIRE_BIT];
    assign wr_period_new = wr_go && wr_idx == cable_diag_pkg::IDX_VAR_CTRL && s_axi_wstrb[0]
                     && wval[cable_diag_pkg::PERIOD_LSB +: 2] != var_period;
    assign rd_data_reg = rd_go && rd_idx == cable_diag_pkg::IDX_VAR_DATA;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= cable_diag_pkg::RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_idx >= cable_diag_pkg::IDX_CONTROL
                             && wr_idx <= cable_diag_pkg::IDX_VAR_DATA)
                            ? cable_diag_pkg::RESP_OKAY : cable_diag_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // read mux; reserved bits read zero
    always_comb begin
        next_rdata = 16'h0000;
        next_rhit  = 1'b1;
        case (rd_idx)
            cable_diag_pkg::IDX_CONTROL: begin
                next_rdata[cable_diag_pkg::FIRE_BIT]      = reflect_pulse_fire;
                next_rdata[cable_diag_pkg::POLARITY_BIT]  = peak_polarity_select;
                next_rdata[cable_diag_pkg::LEVEL_MSB:0]   = trigger_level;
            end
            cable_diag_pkg::IDX_WINDOW:
                next_rdata = {reflect_window_begin, reflect_window_end};
            cable_diag_pkg::IDX_PEAK:
                next_rdata = {2'h0, peak_value, reflect_peak_time};
            cable_diag_pkg::IDX_THRESHOLD:
                next_rdata = {7'h00, reflect_threshold_hit, reflect_threshold_time};
            cable_diag_pkg::IDX_VAR_CTRL: begin
                next_rdata[cable_diag_pkg::READY_BIT]           = var_ready;
                next_rdata[cable_diag_pkg::HOLD_BIT]            = var_hold;
                next_rdata[cable_diag_pkg::PERIOD_LSB +: 2]     = var_period;
                next_rdata[cable_diag_pkg::ENABLE_BIT]          = var_enable;
            end
            cable_diag_pkg::IDX_VAR_DATA:
                next_rdata = read_high ? var_data[31:16] : var_data[15:0];
            default:
                next_rhit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= cable_diag_pkg::RESP_OKAY;
        end else if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {16'h0000, next_rdata};
            s_axi_rresp  <= next_rhit ? cable_diag_pkg::RESP_OKAY : cable_diag_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // reflectometry configuration
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            peak_polarity_select <= 1'b0;
            trigger_level        <= cable_diag_pkg::LEVEL_RESET;
            reflect_window_begin <= cable_diag_pkg::WINDOW_RESET;
            reflect_window_end   <= cable_diag_pkg::WINDOW_RESET;
        end else if (wr_go) begin
            if (wr_idx == cable_diag_pkg::IDX_CONTROL && s_axi_wstrb[0]) begin
                peak_polarity_select <= wval[cable_diag_pkg::POLARITY_BIT];
                trigger_level        <= wval[cable_diag_pkg::LEVEL_MSB:0];
            end
            if (wr_idx == cable_diag_pkg::IDX_WINDOW) begin
                if (s_axi_wstrb[1])
                    reflect_window_begin <= wval[cable_diag_pkg::BEGIN_LSB +: 8];
                if (s_axi_wstrb[0])
                    reflect_window_end <= wval[7:0];
            end
        end
    end

    assign in_window   = win_time >= reflect_window_begin && win_time <= reflect_window_end;
    assign level_met   = peak_polarity_select ? (sample < trigger_level)
                                              : (sample > trigger_level);
    assign peak_better = !peak_seen || (peak_polarity_select ? (sample < peak_value)
                                                             : (sample > peak_value));
    assign cap_last    = win_time == reflect_window_end || win_time == cable_diag_pkg::TIME_LAST;

    // capture sequencing; fire bit self-clears at window end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cap_state          <= CAP_IDLE;
            reflect_pulse_fire <= 1'b0;
            pulse_fire         <= 1'b0;
            win_time           <= 8'h00;
        end else begin
            pulse_fire <= 1'b0;
            case (cap_state)
                CAP_IDLE: begin
                    if (wr_fire) begin
                        cap_state          <= CAP_RUN;
                        reflect_pulse_fire <= 1'b1;
                        pulse_fire         <= 1'b1;
                        win_time           <= 8'h00;
                    end
                end
                CAP_RUN: begin
                    if (sample_valid) begin
                        if (cap_last) begin
                            cap_state          <= CAP_IDLE;
                            reflect_pulse_fire <= 1'b0;
                        end else begin
                            win_time <= win_time + 8'h01;
                        end
                    end
                end
                default: cap_state <= CAP_IDLE;
            endcase
        end
    end

    // peak and threshold results
    always_ff @(posedge aclk) begin
        if (!aresetn || (cap_state == CAP_IDLE && wr_fire)) begin
            peak_value             <= 6'h00;
            reflect_peak_time      <= 8'h00;
            peak_seen              <= 1'b0;
            reflect_threshold_hit  <= 1'b0;
            reflect_threshold_time <= 8'h00;
        end else if (cap_state == CAP_RUN && sample_valid && in_window) begin
            if (peak_better) begin
                peak_value        <= sample;
                reflect_peak_time <= win_time;
                peak_seen         <= 1'b1;
            end
            if (level_met && !reflect_threshold_hit) begin
                reflect_threshold_hit  <= 1'b1;
                reflect_threshold_time <= win_time;
            end
        end
    end

    // variance period timer
    assign units_target = 4'(({2'h0, var_period} + 4'h1) << 1);
    assign unit_tick    = unit_count == 17'(UNIT_CYCLES - 1);
    assign period_end   = var_enable && unit_tick && units_done == units_target - 4'h1;

    always_ff @(posedge aclk) begin
        if (!aresetn || !var_enable || wr_period_new) begin
            unit_count <= 17'h00000;
            units_done <= 4'h0;
            var_acc    <= 32'h0000_0000;
        end else begin
            unit_count <= unit_tick ? 17'h00000 : unit_count + 17'h00001;
            if (period_end)
                units_done <= 4'h0;
            else if (unit_tick)
                units_done <= units_done + 4'h1;
            if (period_end)
                var_acc <= variance_term_valid ? {16'h0000, variance_term} : 32'h0000_0000;
            else if (variance_term_valid)
                var_acc <= var_acc + {16'h0000, variance_term};
        end
    end

    // variance data, ready, hold and read order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            var_data  <= 32'h0000_0000;
            var_ready <= 1'b0;
        end else if (period_end && !var_hold) begin
            var_data  <= var_acc;
            var_ready <= 1'b1;
        end else if (rd_data_reg && read_high) begin
            var_ready <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            var_hold   <= 1'b0;
            var_period <= cable_diag_pkg::PERIOD_RESET;
            var_enable <= 1'b0;
            read_high  <= 1'b0;
        end else begin
            // a data read in the same cycle as a control write toggles read_high unless the write raises hold; the written hold value wins
            if (rd_data_reg) begin
                read_high <= !read_high;
                if (read_high)
                    var_hold <= 1'b0;
            end
            if (wr_go && wr_idx == cable_diag_pkg::IDX_VAR_CTRL && s_axi_wstrb[0]) begin
                var_hold   <= wval[cable_diag_pkg::HOLD_BIT];
                var_period <= wval[cable_diag_pkg::PERIOD_LSB +: 2];
                var_enable <= wval[cable_diag_pkg::ENABLE_BIT];
                if (wval[cable_diag_pkg::HOLD_BIT] && !var_hold)
                    read_high <= 1'b0;
            end
        end
    end

    sequence s_fire_taken;
        cap_state == CAP_IDLE && wr_fire;
    endsequence
    sequence s_capture_done;
        cap_state == CAP_RUN && sample_valid && cap_last;
    endsequence

    property p_fire_pulse;
        @(posedge aclk) disable iff (!aresetn)
        s_fire_taken |=> pulse_fire && reflect_pulse_fire && peak_value == 6'h00
                         && !reflect_threshold_hit;
    endproperty
    a_fire_pulse: assert property (p_fire_pulse) else $error("fire did not arm capture");

    property p_fire_clears;
        @(posedge aclk) disable iff (!aresetn)
        s_capture_done |=> !reflect_pulse_fire ##1 (!reflect_pulse_fire || $rose(reflect_pulse_fire));
    endproperty
    a_fire_clears: assert property (p_fire_clears) else $error("fire bit held after capture");

    property p_outside_window;
        @(posedge aclk) disable iff (!aresetn)
        cap_state == CAP_RUN && sample_valid && win_time < reflect_window_begin
        |=> $stable(peak_value) && $stable(reflect_threshold_hit);
    endproperty
    a_outside_window: assert property (p_outside_window) else $error("sample outside window used");

    property p_threshold_first;
        @(posedge aclk) disable iff (!aresetn)
        cap_state == CAP_RUN && sample_valid && in_window && level_met && !reflect_threshold_hit
        |=> reflect_threshold_hit && reflect_threshold_time == $past(win_time);
    endproperty
    a_threshold_first: assert property (p_threshold_first) else $error("threshold hit not taken");

    property p_peak_equal;
        @(posedge aclk) disable iff (!aresetn)
        cap_state == CAP_RUN && sample_valid && peak_seen && sample == peak_value
        |=> $stable(reflect_peak_time);
    endproperty
    a_peak_equal: assert property (p_peak_equal) else $error("peak time moved on equal sample");

    property p_reserved_zero;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("upper read bits not zero");

    property p_two_reads_clear;
        @(posedge aclk) disable iff (!aresetn)
        rd_data_reg && read_high && !(period_end && !var_hold) && !wr_go
        |=> !var_ready && !var_hold && !read_high;
    endproperty
    a_two_reads_clear: assert property (p_two_reads_clear) else $error("ready or hold not cleared");

    property p_hold_freezes;
        @(posedge aclk) disable iff (!aresetn)
        var_hold && period_end |=> $stable(var_data);
    endproperty
    a_hold_freezes: assert property (p_hold_freezes) else $error("data changed under hold");

    property p_period_restart;
        @(posedge aclk) disable iff (!aresetn)
        wr_period_new |=> unit_count == 17'h00000 && units_done == 4'h0 && var_acc == 32'h0;
    endproperty
    a_period_restart: assert property (p_period_restart) else $error("period write did not restart");

    property p_low_half_first;
        @(posedge aclk) disable iff (!aresetn)
        rd_data_reg && !read_high |=> s_axi_rdata[15:0] == $past(var_data[15:0]);
    endproperty
    a_low_half_first: assert property (p_low_half_first) else $error("first read not low half");
endmodule
`default_nettype wire

//--- verification/cable_model.sv
// cable under test: answers each fired pulse with a reflected sample train
// assumes pulse_fire is a one-cycle strobe on aclk
`timescale 1ns/1ps
`default_nettype none
module cable_model (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       fire,
    input  wire logic       slow,
    output logic [5:0]      sample,
    output logic            sample_valid
);
    // echo shape for window times 0 to 9, mid level after
    localparam logic [5:0] SHAPE [10] = '{6'h20, 6'h22, 6'h30, 6'h25, 6'h30,
                                          6'h12, 6'h10, 6'h1E, 6'h10, 6'h28};
    logic [7:0] t;
    logic       run;
    logic       gap;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run          <= 1'b0;
            t            <= 8'h00;
            gap          <= 1'b0;
            sample_valid <= 1'b0;
            sample       <= 6'h2A;
        end else if (fire) begin
            run          <= 1'b1;
            t            <= 8'h00;
            gap          <= 1'b0;
            sample_valid <= 1'b0;
            sample       <= ~sample;
        end else if (run && !(slow && gap)) begin
            sample_valid <= 1'b1;
            sample       <= (t < 8'h0A) ? SHAPE[t] : 6'h20;
            t            <= t + 8'h01;
            run          <= (t != 8'hFF);
            gap          <= 1'b1;
        end else begin
            // idle line carries no stale value
            sample_valid <= 1'b0;
            sample       <= ~sample;
            gap          <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- verification/cable_diag_results_tb_top.sv
// testbench: register bus tasks, capture and variance scenarios
// assumes cable_model answers pulse_fire with a sample train
`timescale 1ns/1ps
`default_nettype none
module cable_diag_results_tb_top;
    localparam logic [5:0] CTL = cable_diag_pkg::IDX_CONTROL;
    localparam logic [5:0] WIN = cable_diag_pkg::IDX_WINDOW;
    localparam logic [5:0] PK  = cable_diag_pkg::IDX_PEAK;
    localparam logic [5:0] THR = cable_diag_pkg::IDX_THRESHOLD;
    localparam logic [5:0] VC  = cable_diag_pkg::IDX_VAR_CTRL;
    localparam logic [5:0] VD  = cable_diag_pkg::IDX_VAR_DATA;
    logic        aclk, aresetn = 1'b0, slow = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, variance_term_valid = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [5:0]  sample;
    logic        sample_valid, pulse_fire;
    logic [15:0] variance_term = 16'h0, d;
    int          mismatches = 0, checked = 0;

    cable_diag_results #(.UNIT_CYCLES(8)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sample, .sample_valid,
        .pulse_fire, .variance_term, .variance_term_valid);
    cable_model model (.aclk, .aresetn, .fire(pulse_fire), .slow, .sample, .sample_valid);

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic results;
        if (mismatches == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [5:0] idx, input logic [15:0] v);
        s_axi_awaddr  <= {idx, 2'b00};
        s_axi_wdata   <= {16'h0000, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do @(posedge aclk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid  <= 1'b0;
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready  <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rd(input logic [5:0] idx);
        s_axi_araddr  <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata[15:0];
        r = s_axi_rresp;
        s_axi_rready  <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rc(input string nm, input logic [5:0] idx, input logic [15:0] e);
        rd(idx);
        chk(nm, {16'h0000, d}, {16'h0000, e});
    endtask

    task automatic terms(input logic [15:0] v, input int n);
        variance_term       <= v;
        variance_term_valid <= 1'b1;
        repeat (n) @(posedge aclk);
        variance_term_valid <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic t_reset_and_reserved;
        rc("ctl reset", CTL, 16'h0020);
        rc("win reset", WIN, 16'h0000);
        wr(PK, 16'hFFFF);
        rc("peak ro", PK, 16'h0000);
        wr(THR, 16'hFFFF);
        rc("thr ro", THR, 16'h0000);
        wr(VC, 16'hFFF0);
        terms(16'h0001, 4);
        repeat (40) @(posedge aclk);
        rc("var off", VC, 16'h0000);
        wr(6'h3F, 16'h0001);
        chk("unmapped bresp", {30'h0, r}, {30'h0, cable_diag_pkg::RESP_SLVERR});
        rc("unmapped data", 6'h3F, 16'h0000);
        chk("unmapped rresp", {30'h0, r}, {30'h0, cable_diag_pkg::RESP_SLVERR});
    endtask

    task automatic cap(input logic [15:0] win, ctl, input logic slw, input logic [15:0] pk, th);
        slow <= slw;
        wr(WIN, win);
        rc("win rw", WIN, win);
        wr(CTL, ctl | 16'h0800);
        rc("fire held", CTL, ctl | 16'h0800);
        do rd(CTL); while (d[11] !== 1'b0);
        chk("ctl after", {16'h0, d}, {16'h0, ctl});
        rc("peak", PK, pk);
        rc("thr", THR, th);
    endtask

    task automatic t_period;
        for (int p = 0; p < 4; p++) begin
            wr(VC, 16'h0000);
            rd(VD);
            rd(VD);
            wr(VC, 16'(p * 2 + 1));
            repeat (16 * (p + 1) - 6) @(posedge aclk);
            rc("not yet", VC, 16'(p * 2 + 1));
            for (int k = 0; k < 10 && d[15] !== 1'b1; k++) rd(VC);
            chk("ready", {16'h0, d}, 32'(16'h8000 | p * 2 + 1));
        end
    endtask

    task automatic t_sum;
        wr(VC, 16'h0000);
        rd(VD);
        rd(VD);
        wr(VC, 16'h0007);
        terms(16'hAAAB, 3);
        do rd(VC); while (d[15] !== 1'b1);
        rd(VD);
        wr(VC, 16'h000F);
        terms(16'h1111, 5);
        repeat (70) @(posedge aclk);
        rc("frozen", VC, 16'h800F);
        rc("low half", VD, 16'h0001);
        rc("high half", VD, 16'h0002);
        rc("auto clear", VC, 16'h0007);
    endtask

    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset_and_reserved();
        cap(16'h0108, 16'h0024, 1'b0, 16'h3002, 16'h0102);
        cap(16'h0309, 16'h0091, 1'b1, 16'h1006, 16'h0106);
        cap(16'h0004, 16'h0030, 1'b1, 16'h3002, 16'h0000);
        t_period();
        t_sum();
        results();
    end

    initial begin
        repeat (6000) @(posedge aclk);
        mismatches++;
        results();
    end
endmodule
`default_nettype wire
